// *** hdl/dea_access_ctrl.v ***
// Purpose: control of reads and self-timed writes to the data array
// Assumes: AHB-Lite slave, single word transfers, one clock
// Notes: write cycle and power-up block lengths are parameters
`timescale 1ns/100ps
`default_nettype none
`include "dea_map.vh"
module dea_access_ctrl
#(
  parameter WRITE_CYC = `DEA_WRITE_CYC,
  parameter PWRUP_CYC = `DEA_PWRUP_CYC
)
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire code_protect,
  input wire ext_req,
  input wire ext_wr,
  input wire [9:0] ext_addr,
  input wire [7:0] ext_wdata,
  output reg [7:0] ext_rdata,
  output wire ext_refused,
  output wire prog_write_req,
  output wire prog_erase_req,
  output wire cfg_write_req,
  output wire [7:0] peripheral_flags_two
);
  localparam K_IDLE = 2'd0;
  localparam K_ONE = 2'd1;
  localparam K_TWO = 2'd2;

  reg [7:0] array_address_low_q;
  reg [1:0] array_address_high_q;
  reg [7:0] array_data_holding_q;
  reg memory_space_select_q;
  reg configuration_select_q;
  reg erase_q;
  reg write_error_flag_q;
  reg write_permit_q;
  reg wstart_q;
  reg write_done_flag_q;
  reg [1:0] key_q;
  reg [31:0] wcnt_q;
  reg [31:0] pcnt_q;
  reg pwr_busy_q;
  reg ap_q;
  reg ap_wr_q;
  reg [7:0] ap_ofs_q;
  reg [7:0] rdata_c;
  wire [7:0] arr_rdata;
  wire [9:0] arr_addr;
  wire [7:0] arr_wdata;
  wire arr_wr;
  wire wr_ctrl;
  wire wr_key;
  wire wr_lo;
  wire wr_hi;
  wire wr_data;
  wire wr_flags;
  wire rd_go;
  wire wr_go;
  wire w_done;
  wire ext_ok;
  wire [7:0] wb;

  function sel;
    input [7:0] ofs;
    input [7:0] want;
    begin
      sel = (ofs == want);
    end
  endfunction

  // address phase captured, data phase acts one cycle later
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_q <= 1'b0;
      ap_wr_q <= 1'b0;
      ap_ofs_q <= 8'h00;
    end
    else if (hready)
    begin
      ap_q <= hsel && htrans[1];
      ap_wr_q <= hwrite;
      ap_ofs_q <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wb = hwdata[7:0];
  assign wr_lo = ap_q && ap_wr_q && sel(ap_ofs_q, `DEA_OFS_ADDR_LO);
  assign wr_hi = ap_q && ap_wr_q && sel(ap_ofs_q, `DEA_OFS_ADDR_HI);
  assign wr_ctrl = ap_q && ap_wr_q && sel(ap_ofs_q, `DEA_OFS_CTRL);
  assign wr_key = ap_q && ap_wr_q && sel(ap_ofs_q, `DEA_OFS_KEY);
  assign wr_data = ap_q && ap_wr_q && sel(ap_ofs_q, `DEA_OFS_DATA);
  assign wr_flags = ap_q && ap_wr_q && sel(ap_ofs_q, `DEA_OFS_FLAGS);

  // permit must already be stored; the same write cannot supply it
  assign wr_go = wr_ctrl && wb[`DEA_BIT_WSTART] && !wstart_q &&
    write_permit_q && (key_q == K_TWO) && !pwr_busy_q;
  assign rd_go = wr_ctrl && wb[`DEA_BIT_RSTART] && !wstart_q &&
    !wb[`DEA_BIT_SPACE] && !wb[`DEA_BIT_CFG];
  assign w_done = wstart_q && (wcnt_q == 32'd1);

  // unlock tracker: any other write in between breaks the sequence, reads do not
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      key_q <= K_IDLE;
    end
    else if (ap_q && ap_wr_q)
    begin
      if (wr_key && wb == `DEA_KEY_FIRST)
      begin
        key_q <= K_ONE;
      end
      else if (wr_key && wb == `DEA_KEY_SECOND && key_q == K_ONE)
      begin
        key_q <= K_TWO;
      end
      else
      begin
        key_q <= K_IDLE;
      end
    end
  end

  // power-up timer window keeps the array write path shut
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pcnt_q <= 32'd0;
      pwr_busy_q <= 1'b1;
    end
    else if (pwr_busy_q)
    begin
      pcnt_q <= pcnt_q + 32'd1;
      if (pcnt_q >= PWRUP_CYC - 1)
      begin
        pwr_busy_q <= 1'b0;
      end
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      array_address_low_q <= `DEA_RST_BYTE;
      array_address_high_q <= 2'b00;
      array_data_holding_q <= `DEA_RST_BYTE;
      memory_space_select_q <= 1'b0;
      configuration_select_q <= 1'b0;
      erase_q <= 1'b0;
      write_permit_q <= 1'b0;
      wstart_q <= 1'b0;
      wcnt_q <= 32'd0;
    end
    else
    begin
      if (wstart_q)
      begin
        wcnt_q <= wcnt_q - 32'd1;
        if (w_done)
        begin
          wstart_q <= 1'b0;
          erase_q <= 1'b0;
        end
      end
      else
      begin
        // frozen while a write runs
        if (wr_lo)
        begin
          array_address_low_q <= wb;
        end
        if (wr_hi)
        begin
          array_address_high_q <= wb[1:0];
        end
        if (wr_data)
        begin
          array_data_holding_q <= wb;
        end
        if (wr_ctrl)
        begin
          memory_space_select_q <= wb[`DEA_BIT_SPACE];
          configuration_select_q <= wb[`DEA_BIT_CFG];
          erase_q <= wb[`DEA_BIT_ERASE];
          write_permit_q <= wb[`DEA_BIT_PERMIT];
        end
        if (wr_go)
        begin
          wstart_q <= 1'b1;
          wcnt_q <= WRITE_CYC;
        end
        if (rd_go && !wr_data)
        begin
          array_data_holding_q <= arr_rdata;
        end
      end
    end
  end

  // error flag and done flag; set beats a software clear
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      write_error_flag_q <= 1'b0;
      write_done_flag_q <= 1'b0;
    end
    else
    begin
      if (wr_go)
      begin
        write_error_flag_q <= 1'b1;
      end
      else if (w_done)
      begin
        write_error_flag_q <= 1'b0;
      end
      else if (wr_ctrl && !wstart_q && !wb[`DEA_BIT_WERR])
      begin
        write_error_flag_q <= 1'b0;
      end
      if (w_done)
      begin
        write_done_flag_q <= 1'b1;
      end
      else if (wr_flags && !wb[`DEA_BIT_DONE])
      begin
        write_done_flag_q <= 1'b0;
      end
    end
  end

  // bus side commits to the data array at the end of the timed cycle only; external port writes commit at once
  assign arr_wr = w_done && !memory_space_select_q &&
    !configuration_select_q;
  assign prog_write_req = w_done && memory_space_select_q &&
    !configuration_select_q && !erase_q;
  assign prog_erase_req = w_done && memory_space_select_q &&
    !configuration_select_q && erase_q;
  assign cfg_write_req = w_done && configuration_select_q;
  assign ext_ok = ext_req && !code_protect && !wstart_q && !pwr_busy_q;
  assign ext_refused = ext_req && !ext_ok;
  assign arr_addr = (ext_ok && !wstart_q) ? ext_addr :
    {array_address_high_q, array_address_low_q};
  assign arr_wdata = ext_ok ? ext_wdata : array_data_holding_q;

  // external port shares the array; internal bus side has priority
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_rdata <= 8'h00;
    end
    else if (ext_ok && !ext_wr)
    begin
      ext_rdata <= arr_rdata;
    end
  end

  dea_array u_array
  (
    .hclk(hclk),
    .wr_en(arr_wr || (ext_ok && ext_wr && !rd_go)),
    .addr(rd_go ? {array_address_high_q, array_address_low_q} : arr_addr),
    .wdata(arr_wdata),
    .rdata(arr_rdata)
  );

  assign peripheral_flags_two = {3'b000, write_done_flag_q, 4'h0};

  always @*
  begin
    rdata_c = 8'h00;
    if (sel(ap_ofs_q, `DEA_OFS_ADDR_LO))
    begin
      rdata_c = array_address_low_q;
    end
    else if (sel(ap_ofs_q, `DEA_OFS_ADDR_HI))
    begin
      rdata_c = {6'h00, array_address_high_q};
    end
    else if (sel(ap_ofs_q, `DEA_OFS_CTRL))
    begin
      rdata_c = {memory_space_select_q, configuration_select_q, 1'b0,
        erase_q, write_error_flag_q, write_permit_q, wstart_q, 1'b0};
    end
    else if (sel(ap_ofs_q, `DEA_OFS_DATA))
    begin
      rdata_c = array_data_holding_q;
    end
    else if (sel(ap_ofs_q, `DEA_OFS_FLAGS))
    begin
      rdata_c = peripheral_flags_two;
    end
    else if (sel(ap_ofs_q, `DEA_OFS_STATUS))
    begin
      rdata_c = {7'h00, pwr_busy_q};
    end
    // key port reads zero, unmapped too
  end

  always @*
  begin
    hrdata = {24'h000000, rdata_c};
  end
endmodule
`default_nettype wire

// *** include/dea_map.vh ***
// Purpose: register map and timing constants of the data array access block
// Assumes: AHB-Lite word registers, 100 MHz hclk
// Notes: definitions only
`ifndef DEA_MAP_VH
`define DEA_MAP_VH
`define DEA_OFS_ADDR_LO 8'h00
`define DEA_OFS_ADDR_HI 8'h04
`define DEA_OFS_CTRL 8'h08
`define DEA_OFS_KEY 8'h0c
`define DEA_OFS_DATA 8'h10
`define DEA_OFS_FLAGS 8'h14
`define DEA_OFS_STATUS 8'h18
`define DEA_BIT_SPACE 7
`define DEA_BIT_CFG 6
`define DEA_BIT_ERASE 4
`define DEA_BIT_WERR 3
`define DEA_BIT_PERMIT 2
`define DEA_BIT_WSTART 1
`define DEA_BIT_RSTART 0
`define DEA_BIT_DONE 4
`define DEA_KEY_FIRST 8'h55
`define DEA_KEY_SECOND 8'haa
`define DEA_RST_CTRL 8'h00
`define DEA_RST_BYTE 8'h00
`define DEA_WRITE_NS 4000000
`define DEA_PWRUP_NS 65000000
`define DEA_CLK_NS 10
`define DEA_WRITE_CYC (`DEA_WRITE_NS / `DEA_CLK_NS)
`define DEA_PWRUP_CYC (`DEA_PWRUP_NS / `DEA_CLK_NS)
`endif

// *** hdl/dea_array.v ***
// Purpose: byte wide nonvolatile data array model, 1024 locations
// Assumes: one write port, combinational read port
// Notes: contents undefined until written, as real cells hold old data
`timescale 1ns/100ps
`default_nettype none
module dea_array
(
  input wire hclk,
  input wire wr_en,
  input wire [9:0] addr,
  input wire [7:0] wdata,
  output wire [7:0] rdata
);
  reg [7:0] mem [0:1023];

  // erase-before-write collapses to a plain overwrite in this model
  always @(posedge hclk)
  begin
    if (wr_en)
    begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];
endmodule
`default_nettype wire

// *** sim/dea_access_monitor.sv ***
// Purpose: port level checks for the array access block
// Assumes: zero wait slave, one clock domain
// Notes: bound from the testbench top file
`timescale 1ns/100ps
`default_nettype none
module dea_access_monitor
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire code_protect,
  input wire ext_req,
  input wire ext_refused,
  input wire prog_write_req,
  input wire prog_erase_req,
  input wire cfg_write_req,
  input wire [7:0] peripheral_flags_two
);
  reg dp_q;
  reg wr_q;
  reg [7:0] a_q;
  wire rd = dp_q && !wr_q;
  wire rk = rd && a_q == 8'h0c;
  wire rc = rd && a_q == 8'h08;
  wire fw = dp_q && wr_q && a_q == 8'h14;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      dp_q <= 1'b0;
    else
      dp_q <= hsel && htrans[1] && hready;
  // address and direction need no reset, only read beside dp_q
  always @(posedge hclk)
  begin
    wr_q <= hwrite;
    a_q <= haddr[7:0];
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  okay_zero_wait_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  key_reads_zero_a: assert property (rk |-> hrdata == 32'h0)
    else $error("key port read not zero");
  read_start_low_a: assert property (rc |-> !hrdata[0])
    else $error("read start bit seen set");
  error_in_write_a: assert property (rc && hrdata[1] |-> hrdata[3])
    else $error("error flag clear during write");
  protect_refuse_a: assert property (ext_req && code_protect |-> ext_refused)
    else $error("external access not refused");
  done_after_write_a: assert property (prog_write_req |-> ##[0:1] peripheral_flags_two[4])
    else $error("done flag not set after write");
  done_held_a: assert property ($fell(peripheral_flags_two[4]) |-> $past(fw))
    else $error("done flag cleared without software");
  one_pulse_a: assert property (prog_write_req |=> !prog_write_req)
    else $error("completion pulse too long");
  erase_pulse_a: assert property (prog_erase_req |=> !prog_erase_req)
    else $error("erase pulse too long");
  single_target_a: assert property (!(prog_write_req && cfg_write_req))
    else $error("two targets at once");
  cover property (rk);
  cover property (prog_write_req);
  cover property (cfg_write_req);
  cover property (prog_erase_req);
endmodule
`default_nettype wire

// *** sim/tb_dea_access_ctrl.sv ***
// Purpose: register level test of the array access block
// Assumes: AHB-Lite single word transfers, short write and power-up counts
// Notes: prints mismatches and the verdict only
`timescale 1ns/100ps
`default_nettype none
module tb_dea_access_ctrl;
  localparam WC = 20;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h0;
  reg code_protect = 1'b0;
  reg ext_req = 1'b0;
  reg ext_wr = 1'b0;
  reg [9:0] ext_addr = 10'h2a5;
  reg [7:0] ext_wdata = 8'h00;
  wire hready, hresp, ext_refused, prog_write_req, prog_erase_req;
  wire cfg_write_req;
  wire [31:0] hrdata;
  wire [7:0] ext_rdata, peripheral_flags_two;
  reg [31:0] rd_q, cap_q;
  reg [7:0] m;
  integer miscompares = 0;
  integer comparisons = 0;
  integer i;
  integer n_pw = 0;
  integer n_pe = 0;
  integer n_cw = 0;
  always #5 hclk = ~hclk;
  always @(posedge hclk)
    cap_q <= hrdata;
  // completion pulses counted per target, skipped while in reset
  always @(posedge hclk)
  begin
    if (hresetn)
    begin
      n_pw <= n_pw + prog_write_req;
      n_pe <= n_pe + prog_erase_req;
      n_cw <= n_cw + cfg_write_req;
    end
  end
  dea_access_ctrl #(.WRITE_CYC(WC), .PWRUP_CYC(10)) u_dut (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout(hready), .hresp, .hrdata, .code_protect, .ext_req, .ext_wr,
    .ext_addr, .ext_wdata, .ext_rdata, .ext_refused, .prog_write_req,
    .prog_erase_req, .cfg_write_req, .peripheral_flags_two);
  task close_out;
    begin
      if (miscompares == 0 && comparisons > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        miscompares = miscompares + 1;
        $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hready !== 1'b1)
        @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1)
        @(posedge hclk);
      // let the capture of this edge land first
      #1 rd_q = cap_q;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      chk(rd_q, e);
    end
  endtask
  task wseq(input [7:0] p, input [7:0] k, input [7:0] c);
    begin
      xfer(1'b1, 8'h08, {24'h0, p});
      xfer(1'b1, 8'h0c, {24'h0, k});
      xfer(1'b1, 8'h0c, 32'haa);
      xfer(1'b1, 8'h08, {24'h0, c});
    end
  endtask
  initial
  begin
    #50000;
    miscompares = miscompares + 1;
    close_out;
  end
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h08, 32'h0);
    rd(8'h18, 32'h1);
    rd(8'h0c, 32'h0);
    repeat (12) @(posedge hclk);
    rd(8'h18, 32'h0);
    xfer(1'b1, 8'h00, 32'ha5);
    xfer(1'b1, 8'h04, 32'h2);
    xfer(1'b1, 8'h10, 32'h3c);
    wseq(8'h04, 8'h55, 8'h06);
    rd(8'h08, 32'h0e);
    xfer(1'b1, 8'h10, 32'h11);
    xfer(1'b1, 8'h08, 32'h04);
    rd(8'h08, 32'h0e);
    repeat (WC + 4) @(posedge hclk);
    rd(8'h08, 32'h04);
    rd(8'h10, 32'h3c);
    rd(8'h14, 32'h10);
    rd(8'h14, 32'h10);
    xfer(1'b1, 8'h14, 32'h0);
    rd(8'h14, 32'h0);
    xfer(1'b1, 8'h04, 32'h0);
    xfer(1'b1, 8'h10, 32'hc3);
    wseq(8'h04, 8'h55, 8'h06);
    repeat (WC + 4) @(posedge hclk);
    xfer(1'b1, 8'h04, 32'h2);
    xfer(1'b1, 8'h08, 32'h05);
    rd(8'h10, 32'h3c);
    rd(8'h10, 32'h3c);
    xfer(1'b1, 8'h04, 32'h0);
    for (i = 0; i < 2; i = i + 1)
      xfer(1'b1, 8'h08, i ? 32'h41 : 32'h81);
    rd(8'h10, 32'h3c);
    rd(8'h08, 32'h40);
    wseq(8'h04, 8'haa, 8'h06);
    rd(8'h08, 32'h04);
    wseq(8'h00, 8'h55, 8'h06);
    rd(8'h08, 32'h04);
    wseq(8'h00, 8'h55, 8'h02);
    rd(8'h08, 32'h00);
    for (i = 0; i < 3; i = i + 1)
    begin
      m = i == 0 ? 8'h84 : i == 1 ? 8'h94 : 8'hc4;
      wseq(m | 8'h04, 8'h55, m | 8'h06);
      repeat (WC + 4) @(posedge hclk);
      rd(8'h08, {24'h0, m & 8'hef | 8'h04});
    end
    chk(n_pw, 32'h1);
    chk(n_pe, 32'h1);
    chk(n_cw, 32'h1);
    @(posedge hclk);
    code_protect <= 1'b1;
    ext_req <= 1'b1;
    @(negedge hclk);
    chk(ext_refused, 32'h1);
    xfer(1'b1, 8'h08, 32'h05);
    rd(8'h10, 32'hc3);
    @(posedge hclk);
    code_protect <= 1'b0;
    @(negedge hclk);
    chk(ext_refused, 32'h0);
    @(negedge hclk);
    chk(ext_rdata, 32'h3c);
    // second reset: power-up window must shut the external path again
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk(ext_refused, 32'h1);
    rd(8'h08, 32'h0);
    rd(8'h18, 32'h1);
    close_out;
  end
endmodule
bind dea_access_ctrl dea_access_monitor u_mon (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .code_protect, .ext_req, .ext_refused, .prog_write_req, .prog_erase_req,
  .cfg_write_req, .peripheral_flags_two);
`default_nettype wire
